// ===== design/idc_handler.sv
// command handler for focus, calibration and multiplier bias commands
module idc_handler
    import idc_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic [7:0]                paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      filament_emitting_pin,
    input  wire logic                      multiplier_option_pin,
    output logic      [idc_pkg::FOCUS_W-1:0] focus_bias_value,
    output logic                           focus_bias_load,
    output logic      [idc_pkg::ARG_W-1:0] multiplier_bias_value,
    output logic                           negative_current_mode,
    output logic                           amp_zero_req,
    input  wire logic                      amp_zero_ack,
    input  wire logic [idc_pkg::DATA_W-1:0] amp_zero_data,
    output logic                           axis_recal_req,
    input  wire logic                      axis_recal_ack,
    output logic                           filter_drive_off,
    output logic                           full_cal_req,
    input  wire logic                      full_cal_ack,
    input  wire logic                      scan_start,
    input  wire logic                      scan_single_mass,
    input  wire logic                      meas_valid,
    input  wire logic [idc_pkg::DATA_W-1:0] meas_raw,
    output logic                           meas_corr_valid,
    output logic      [idc_pkg::DATA_W-1:0] meas_corr,
    output logic                           reply_valid,
    input  wire logic                      reply_ready,
    output logic      [idc_pkg::DATA_W-1:0] reply_data,
    output logic                           reply_is_query,
    output logic                           busy
);
    import idc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EXEC,
        ST_ZERO,
        ST_AXIS,
        ST_FILT_OFF,
        ST_FULLCAL,
        ST_REPLY
    } idc_state_t;

    typedef struct packed {
        idc_state_t              st;
        logic [FOCUS_W-1:0]      focus;
        logic [ARG_W-1:0]        mult;
        logic                    neg_mode;
        logic [NF_W-1:0]         nf;
        logic [3:0]              op;
        logic [1:0]              form;
        logic                    nonint;
        logic [ARG_W-1:0]        arg;
        logic                    scan_only;
        logic                    single;
        logic [(1<<SLOT_W)-1:0]  offs_ok;
        logic [DATA_W-1:0]       reply;
        logic                    rq;
        logic                    err_cmd;
        logic                    err_param;
        logic                    focus_load;
        logic                    filt_off;
        logic [31:0]             prdata;
        logic [2:0]              fil_s;
        logic [2:0]              opt_s;
        logic                    fil;
        logic                    opt;
        logic                    mv1;
        logic [DATA_W-1:0]       raw1;
        logic [SLOT_W-1:0]       slot1;
        logic                    mv2;
        logic [DATA_W-1:0]       corr;
    } idc_regs_t;

    localparam idc_regs_t REGS_RESET = '{
        st: ST_IDLE, focus: FOCUS_DEF, mult: MULT_RESET, nf: NF_RESET,
        default: '0
    };

    idc_regs_t r;
    idc_regs_t n;

    logic              mem_we;
    logic [DATA_W-1:0] mem_rdata;
    logic              setup;
    logic              access;
    logic              bad_addr;
    logic              cmd_refused;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [SLOT_W-1:0] idc_slot(
        input logic            det,
        input logic [NF_W-1:0] nf
    );
        idc_slot = {det, nf};
    endfunction : idc_slot

    function automatic logic idc_known(input logic [7:0] a);
        idc_known = (a == ADDR_CMD) || (a == ADDR_STATUS) ||
                    (a == ADDR_CONFIG) || (a == ADDR_FOCUS) ||
                    (a == ADDR_MULT) || (a == ADDR_OFFS);
    endfunction : idc_known

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    // read data is captured in the setup cycle, so no wait state
    assign setup       = psel && !penable;
    assign access      = psel && penable;
    assign bad_addr    = !idc_known(paddr);
    // a command written while one is still open is refused
    assign cmd_refused = pwrite && (paddr == ADDR_CMD) && (r.st != ST_IDLE);
    assign pready      = 1'b1;
    assign pslverr     = access && (bad_addr || cmd_refused);

    // ------------------------------------------------------------
    // offset store
    // ------------------------------------------------------------
    assign mem_we = (r.st == ST_ZERO) && amp_zero_ack;

    idc_offset_mem #(
        .AW (SLOT_W),
        .DW (DATA_W)
    ) u_offs (
        .sys_clk (sys_clk),
        .we      (mem_we),
        .waddr   (idc_slot(r.neg_mode, r.nf)),
        .wdata   (amp_zero_data),
        .raddr   (idc_slot(r.neg_mode, r.nf)),
        .rdata   (mem_rdata)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        n = r;
        n.focus_load = 1'b0;
        n.filt_off   = 1'b0;

        // pins: a change counts once stages two and three agree
        n.fil_s = {r.fil_s[1:0], filament_emitting_pin};
        n.opt_s = {r.opt_s[1:0], multiplier_option_pin};
        if (r.fil_s[1] == r.fil_s[2])
        begin
            n.fil = r.fil_s[2];
        end
        if (r.opt_s[1] == r.opt_s[2])
        begin
            n.opt = r.opt_s[2];
        end

        // stored focus goes out when emission starts, unless a focus number or default command executes in that cycle
        if (n.fil && !r.fil)
        begin
            n.focus_load = 1'b1;
        end

        // measurement correction, two stages to meet memory latency
        n.mv1   = meas_valid;
        n.raw1  = meas_raw;
        n.slot1 = idc_slot(r.neg_mode, r.nf);
        n.mv2   = r.mv1;
        if (r.mv1)
        begin
            // offset applied only under the settings it was taken at
            if (r.offs_ok[r.slot1] && (mem_rdata <= r.raw1))
            begin
                n.corr = r.raw1 - mem_rdata;
            end
            else if (r.offs_ok[r.slot1])
            begin
                n.corr = '0;
            end
            else
            begin
                n.corr = r.raw1;
            end
        end

        // register reads, captured at setup
        if (setup && !pwrite)
        begin
            case (paddr)
                ADDR_CMD:
                    n.prdata = {4'h0, r.arg, 9'h000, r.nonint,
                                r.form, r.op};
                ADDR_STATUS:
                    n.prdata = {r.reply, 8'h00, 3'h0, r.opt,
                                r.fil, r.err_param, r.err_cmd,
                                (r.st != ST_IDLE)};
                ADDR_CONFIG:
                    n.prdata = {29'h0, r.nf};
                ADDR_FOCUS:
                    n.prdata = {24'h0, r.focus};
                ADDR_MULT:
                    n.prdata = {19'h0, r.neg_mode, r.mult};
                ADDR_OFFS:
                    n.prdata = {16'h0, r.offs_ok};
                default:
                    n.prdata = '0;
            endcase
        end

        if (access && pwrite && (paddr == ADDR_CONFIG))
        begin
            n.nf = pwdata[NF_W-1:0];
        end

        case (r.st)
            ST_IDLE:
            begin
                if (access && pwrite && (paddr == ADDR_CMD))
                begin
                    n.op     = pwdata[CMD_OP_LSB +: 4];
                    n.form   = pwdata[CMD_FORM_LSB +: 2];
                    n.nonint = pwdata[CMD_NONINT];
                    n.arg    = pwdata[CMD_ARG_LSB +: ARG_W];
                    n.st     = ST_EXEC;
                end
                else if (scan_start)
                begin
                    // scans redo the zero; axis only for swept scans
                    n.scan_only = 1'b1;
                    n.single    = scan_single_mass;
                    n.st        = ST_ZERO;
                end
            end
            ST_EXEC:
            begin
                n.err_cmd   = 1'b0;
                n.err_param = 1'b0;
                n.rq        = 1'b0;
                n.scan_only = 1'b0;
                n.single    = 1'b0;
                n.st        = ST_REPLY;
                case (r.op)
                    OP_FOCUS:
                    begin
                        if (r.form == FORM_QUERY)
                        begin
                            n.rq = 1'b1;
                        end
                        else if (r.form == FORM_NONE)
                        begin
                            n.err_param = 1'b1;
                        end
                        else if (r.form == FORM_DEFAULT)
                        begin
                            n.focus      = FOCUS_DEF;
                            n.focus_load = r.fil;
                        end
                        else if (r.nonint || (r.arg > FOCUS_MAX))
                        begin
                            n.err_param = 1'b1;
                        end
                        else
                        begin
                            n.focus      = r.arg[FOCUS_W-1:0];
                            // off filament: value waits for emission
                            n.focus_load = r.fil;
                        end
                    end
                    OP_CALALL:
                    begin
                        if (r.form != FORM_NONE)
                        begin
                            n.err_param = 1'b1;
                        end
                        else
                        begin
                            n.st = ST_ZERO;
                        end
                    end
                    OP_FULLCAL:
                    begin
                        if (r.form != FORM_NONE)
                        begin
                            n.err_param = 1'b1;
                        end
                        else
                        begin
                            n.st = ST_FULLCAL;
                        end
                    end
                    OP_MULT:
                    begin
                        if (!r.opt)
                        begin
                            n.err_cmd = 1'b1;
                        end
                        else if (r.form == FORM_QUERY)
                        begin
                            n.rq = 1'b1;
                        end
                        else if (r.form == FORM_NONE)
                        begin
                            n.err_param = 1'b1;
                        end
                        else if (r.form == FORM_DEFAULT)
                        begin
                            n.mult     = MULT_DEF;
                            n.neg_mode = 1'b1;
                        end
                        else if (r.nonint || (r.arg > MULT_MAX))
                        begin
                            n.err_param = 1'b1;
                        end
                        else
                        begin
                            n.mult     = r.arg;
                            n.neg_mode = (r.arg != '0);
                        end
                    end
                    default:
                    begin
                        n.err_cmd = 1'b1;
                    end
                endcase
            end
            ST_ZERO:
            begin
                // sample held until the amplifier answers
                if (amp_zero_ack)
                begin
                    n.offs_ok[idc_slot(r.neg_mode, r.nf)] = 1'b1;
                    if (r.scan_only && r.single)
                    begin
                        n.st = ST_IDLE;
                    end
                    else
                    begin
                        n.st = ST_AXIS;
                    end
                end
            end
            ST_AXIS:
            begin
                if (axis_recal_ack)
                begin
                    n.st = r.scan_only ? ST_IDLE : ST_FILT_OFF;
                    // drives go off one cycle before the status byte
                    n.filt_off  = !r.scan_only;
                    n.scan_only = 1'b0;
                end
            end
            ST_FILT_OFF:
            begin
                n.st = ST_REPLY;
            end
            ST_FULLCAL:
            begin
                if (full_cal_ack)
                begin
                    n.offs_ok = '0;
                    n.st      = ST_REPLY;
                end
            end
            ST_REPLY:
            begin
                // status leaves before any new command is taken
                if (reply_ready)
                begin
                    n.st = ST_IDLE;
                end
            end
            default:
            begin
                n.st = ST_IDLE;
            end
        endcase

        // reply word is settled on entry to the reply state
        if ((n.st == ST_REPLY) && (r.st != ST_REPLY))
        begin
            if (n.rq && (r.op == OP_FOCUS))
            begin
                n.reply = {{(DATA_W-FOCUS_W){1'b0}}, n.focus};
            end
            else if (n.rq)
            begin
                n.reply = {{(DATA_W-ARG_W){1'b0}}, n.mult};
            end
            else
            begin
                n.reply = '0;
                n.reply[STAT_BAD_CMD]   = n.err_cmd;
                n.reply[STAT_BAD_PARAM] = n.err_param;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // power loss is reset: every offset is forgotten with it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            r <= REGS_RESET;
        end
        else
        begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata                = r.prdata;
    assign focus_bias_value      = r.focus;
    assign focus_bias_load       = r.focus_load;
    assign multiplier_bias_value = r.mult;
    assign negative_current_mode = r.neg_mode;
    assign amp_zero_req          = (r.st == ST_ZERO);
    assign axis_recal_req        = (r.st == ST_AXIS);
    assign full_cal_req          = (r.st == ST_FULLCAL);
    assign filter_drive_off      = r.filt_off;
    assign meas_corr_valid       = r.mv2;
    assign meas_corr             = r.corr;
    assign reply_valid           = (r.st == ST_REPLY);
    assign reply_data            = r.reply;
    assign reply_is_query        = r.rq;
    assign busy                  = (r.st != ST_IDLE);

endmodule : idc_handler

// ===== design/idc_pkg.sv
// constants and encodings for the ionizer and detector command handler
package idc_pkg;

    // -------------------------------------------------------------
    // apb register map (byte addresses)
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_FOCUS  = 8'h0C;
    localparam logic [7:0] ADDR_MULT   = 8'h10;
    localparam logic [7:0] ADDR_OFFS   = 8'h14;

    // -------------------------------------------------------------
    // command word fields
    // -------------------------------------------------------------
    localparam int CMD_OP_LSB    = 0;
    localparam int CMD_FORM_LSB  = 4;
    localparam int CMD_NONINT    = 6;
    localparam int CMD_ARG_LSB   = 16;
    localparam int ARG_W         = 12;

    localparam logic [3:0] OP_FOCUS   = 4'h1;
    localparam logic [3:0] OP_CALALL  = 4'h2;
    localparam logic [3:0] OP_FULLCAL = 4'h3;
    localparam logic [3:0] OP_MULT    = 4'h4;

    localparam logic [1:0] FORM_NONE    = 2'h0;
    localparam logic [1:0] FORM_NUMBER  = 2'h1;
    localparam logic [1:0] FORM_DEFAULT = 2'h2;
    localparam logic [1:0] FORM_QUERY   = 2'h3;

    // -------------------------------------------------------------
    // ranges, defaults, status bits
    // -------------------------------------------------------------
    localparam int FOCUS_W = 8;
    localparam logic [ARG_W-1:0] FOCUS_MAX     = 12'h096;
    localparam logic [FOCUS_W-1:0] FOCUS_DEF   = 8'h5A;
    localparam logic [ARG_W-1:0] MULT_MAX      = 12'h9BA;
    localparam logic [ARG_W-1:0] MULT_DEF      = 12'h578;
    localparam logic [ARG_W-1:0] MULT_RESET    = 12'h000;

    localparam int STAT_BAD_CMD   = 0;
    localparam int STAT_BAD_PARAM = 2;

    localparam int NF_W    = 3;
    localparam logic [NF_W-1:0] NF_RESET = 3'h4;
    localparam int SLOT_W  = NF_W + 1;
    localparam int DATA_W  = 16;

endpackage : idc_pkg

// ===== design/idc_offset_mem.sv
// offset correction store, one word per detector setting
module idc_offset_mem #(
    parameter int AW = 4,
    parameter int DW = 16
) (
    input  wire logic          sys_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset: validity is tracked outside, so erasing is one cycle
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : idc_offset_mem

// ===== test/idc_assertions.sv
// concurrent checks on the command handler ports
module idc_assertions
    import idc_pkg::*;
(
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic [7:0]           paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic                 pslverr,
    input wire logic [FOCUS_W-1:0]   focus_bias_value,
    input wire logic                 focus_bias_load,
    input wire logic [ARG_W-1:0]     multiplier_bias_value,
    input wire logic                 negative_current_mode,
    input wire logic                 amp_zero_req,
    input wire logic                 amp_zero_ack,
    input wire logic                 filter_drive_off,
    input wire logic                 full_cal_req,
    input wire logic                 full_cal_ack,
    input wire logic                 reply_valid,
    input wire logic                 reply_ready,
    input wire logic [DATA_W-1:0]    reply_data,
    input wire logic                 busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------
    // properties
    // -----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_focus_range: assert property (focus_bias_load |->
        {4'h0, focus_bias_value} <= FOCUS_MAX) else $error("focus range");
    a_neg_mode: assert property (negative_current_mode ==
        (multiplier_bias_value != 12'h000)) else $error("neg mode");
    a_mult_range: assert property (
        multiplier_bias_value <= MULT_MAX) else $error("mult range");
    a_reply_hold: assert property (reply_valid && !reply_ready |=>
        reply_valid && $stable(reply_data)) else $error("reply dropped");
    a_reply_done: assert property (
        reply_valid && reply_ready |=> !busy) else $error("busy after status");
    a_cmd_refused: assert property (psel && penable && pwrite &&
        paddr == ADDR_CMD && busy |-> pslverr) else $error("busy write");
    a_filter_reply: assert property (
        filter_drive_off |-> !reply_valid ##1 reply_valid)
        else $error("no status");
    a_zero_hold: assert property (amp_zero_req && !amp_zero_ack |=>
        amp_zero_req) else $error("zero request dropped");
    a_fullcal_reply: assert property (full_cal_req && full_cal_ack |->
        ##[1:2] reply_valid) else $error("no status after cal");
endmodule : idc_assertions

// ===== test/idc_analog_model.sv
// analog front end stand-in answering calibration handshakes
module idc_analog_model
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        amp_zero_req,
    input  wire logic        axis_recal_req,
    input  wire logic        full_cal_req,
    output logic             amp_zero_ack,
    output logic             axis_recal_ack,
    output logic             full_cal_ack,
    output logic      [15:0] amp_zero_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    // -----------------
    // slow answers
    // -----------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_r <= 4'h0;
        else if (!(amp_zero_req | axis_recal_req | full_cal_req))
            cnt_r <= 4'h0;
        else if (amp_zero_ack | axis_recal_ack | full_cal_ack)
            cnt_r <= 4'h0;
        else
            cnt_r <= cnt_r + 4'h1;
    end
    assign amp_zero_ack   = amp_zero_req && cnt_r == 4'h3;
    assign axis_recal_ack = axis_recal_req && cnt_r == 4'h3;
    assign full_cal_ack   = full_cal_req && cnt_r == 4'h7;
    // data meaningless outside the ack, so not held
    assign amp_zero_data = amp_zero_ack ? 16'h0010 : 16'hFFEF;
endmodule : idc_analog_model

// ===== test/idc_handler_test.sv
// self-checking bench for the command handler
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin \
    err_count++; $display("ERROR %s exp %0h got %0h", n, x, g); end end
module idc_handler_test;
    import idc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, focus_bias_load, negative_current_mode, e;
    logic filament_emitting_pin = 0, multiplier_option_pin = 0;
    logic [FOCUS_W-1:0] focus_bias_value;
    logic [ARG_W-1:0] multiplier_bias_value;
    logic amp_zero_req, amp_zero_ack, axis_recal_req, axis_recal_ack;
    logic filter_drive_off, full_cal_req, full_cal_ack, meas_corr_valid;
    logic scan_start = 0, scan_single_mass = 0, meas_valid = 0;
    logic reply_valid, reply_ready = 0, reply_is_query, busy;
    logic [DATA_W-1:0] amp_zero_data, meas_raw = 16'h0, meas_corr;
    logic [DATA_W-1:0] reply_data;
    int err_count = 0, tests_run = 0, loads = 0, offs = 0, l, n;
    localparam logic [15:0] BP = 16'h0001 << STAT_BAD_PARAM;
    localparam logic [15:0] BC = 16'h0001 << STAT_BAD_CMD;
    idc_handler idc_handler_inst (.*);
    idc_analog_model idc_analog_model_inst (.*);
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        loads <= loads + int'(focus_bias_load === 1'b1);
        offs <= offs + int'(filter_drive_off === 1'b1);
    end
    // -----------------
    // tasks
    // -----------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic tmo(input int k);
        if (k >= 200)
        begin
            err_count++;
            $display("ERROR timeout exp 0 got %0d", k);
            end_sim();
        end
    endtask : tmo
    function automatic logic [31:0] c(logic [3:0] op, logic [1:0] f,
                                      logic [11:0] a, logic ni = 1'b0);
        return {4'h0, a, 9'h000, ni, f, op};
    endfunction : c
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n == 0 || (pready !== 1'b1 && n < 200); n++)
            @(posedge sys_clk);
        tmo(n);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wt(input logic [15:0] x);
        for (n = 0; reply_valid !== 1'b1 && n < 200; n++)
            @(posedge sys_clk);
        tmo(n);
        `CHK("reply", x, reply_data)
        @(posedge sys_clk);
        reply_ready <= 1'b1;
        @(posedge sys_clk);
        reply_ready <= 1'b0;
    endtask : wt
    task automatic run(input logic [31:0] w, input logic [15:0] x);
        apb(ADDR_CMD, 1'b1, w);
        wt(x);
    endtask : run
    task automatic pins(input logic f, input logic o);
        filament_emitting_pin <= f;
        multiplier_option_pin <= o;
        repeat (6) @(posedge sys_clk);
    endtask : pins
    // -----------------
    // sequence
    // -----------------
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        apb(ADDR_FOCUS, 1'b0, 32'h0);
        `CHK("focus reset", 32'h5A, q)
        apb(8'h40, 1'b0, 32'h0);
        `CHK("unmapped", 1'b1, e)
        pins(1'b1, 1'b0);
        l = loads;
        run(c(OP_FOCUS, FORM_NUMBER, 12'h096), 16'h0);
        `CHK("load on", l + 1, loads)
        `CHK("focus max", 8'h96, focus_bias_value)
        run(c(OP_FOCUS, FORM_QUERY, 12'h0), 16'h0096);
        `CHK("query flag", 1'b1, reply_is_query)
        run(c(OP_FOCUS, FORM_NUMBER, 12'h097), BP);
        run(c(OP_FOCUS, FORM_NUMBER, 12'h010, 1'b1), BP);
        run(c(OP_FOCUS, FORM_NONE, 12'h0), BP);
        run(c(OP_FOCUS, FORM_DEFAULT, 12'h0), 16'h0);
        `CHK("focus default", 8'h5A, focus_bias_value)
        pins(1'b0, 1'b0);
        l = loads;
        run(c(OP_FOCUS, FORM_NUMBER, 12'h028), 16'h0);
        `CHK("stored only", l, loads)
        pins(1'b1, 1'b0);
        `CHK("applied at emission", l + 1, loads)
        `CHK("focus stored", 8'h28, focus_bias_value)
        $display("test focus done");
        run(c(OP_MULT, FORM_NUMBER, 12'h064), BC);
        pins(1'b1, 1'b1);
        run(c(OP_MULT, FORM_NUMBER, 12'h9BB), BP);
        run(c(OP_MULT, FORM_NUMBER, 12'h9BA), 16'h0);
        apb(ADDR_MULT, 1'b0, 32'h0);
        `CHK("mult reg", 32'h19BA, q)
        $display("test multiplier done");
        run(c(OP_CALALL, FORM_NUMBER, 12'h001), BP);
        l = offs;
        apb(ADDR_CMD, 1'b1, c(OP_CALALL, FORM_NONE, 12'h0));
        apb(ADDR_CMD, 1'b1, c(OP_FOCUS, FORM_NUMBER, 12'h005));
        `CHK("busy refused", 1'b1, e)
        wt(16'h0);
        `CHK("filter off", l + 1, offs)
        `CHK("focus kept", 8'h28, focus_bias_value)
        apb(ADDR_OFFS, 1'b0, 32'h0);
        `CHK("offset slot", 32'h1000, q)
        meas_valid <= 1'b1;
        meas_raw <= 16'h0100;
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        for (n = 0; meas_corr_valid !== 1'b1 && n < 200; n++)
            @(posedge sys_clk);
        tmo(n);
        `CHK("corrected", 16'h00F0, meas_corr)
        apb(ADDR_CONFIG, 1'b1, 32'h2);
        scan_start <= 1'b1;
        @(posedge sys_clk);
        scan_start <= 1'b0;
        @(posedge sys_clk);
        for (n = 0; busy !== 1'b0 && n < 200; n++)
            @(posedge sys_clk);
        tmo(n);
        `CHK("scan no status", l + 1, offs)
        apb(ADDR_OFFS, 1'b0, 32'h0);
        `CHK("scan offset slot", 32'h1400, q)
        $display("test calibrate done");
        run(c(OP_FULLCAL, FORM_QUERY, 12'h0), BP);
        run(c(OP_FULLCAL, FORM_NONE, 12'h0), 16'h0);
        apb(ADDR_OFFS, 1'b0, 32'h0);
        `CHK("offsets cleared", 32'h0, q)
        run(c(4'hF, FORM_NONE, 12'h0), BC);
        $display("test full calibration done");
        end_sim();
    end
endmodule : idc_handler_test
bind idc_handler idc_assertions idc_assertions_inst (.*);
